// ===== bench/tef_host_model.sv
// Purpose: Serial bus host that reads and writes the block's registers
// Assumes: Bus runs far slower than mclk; SDA pulled up, host only pulls low
// Notes: Half SCL period of 8 mclk keeps the 4 mclk minimum with margin
`timescale 1ns/100ps
`default_nettype none

module tef_host_model #(
    parameter logic [6:0] ADDR = 7'h2A
) (
    input wire logic mclk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit level; every change lands just after a clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Data moves only while SCL is low; the line is sampled late in the high phase
    task automatic bit_io(input logic b, output logic seen);
        tick(4);
        sda_pull = ~b;
        tick(4);
        scl = 1'b1;
        tick(6);
        seen = sda_line;
        tick(2);
        scl = 1'b0;
    endtask

    // Serves as repeated start too: SDA is released before SCL rises
    task automatic start_cond();
        tick(4);
        sda_pull = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_pull = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask

    task automatic stop_cond();
        tick(4);
        sda_pull = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_pull = 1'b0;
        tick(4);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Byte level, MSB first
    task automatic byte_out(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    // A high last bit releases SDA, which ends the read
    task automatic byte_in(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(last, s);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Register transfers; ok is high only when every byte the host sent was acknowledged
    task automatic write_reg(input logic [7:0] p, input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start_cond();
        byte_out({ADDR, 1'b0}, a0);
        byte_out(p, a1);
        byte_out(d, a2);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask

    task automatic read_reg(input logic [7:0] p, output logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start_cond();
        byte_out({ADDR, 1'b0}, a0);
        byte_out(p, a1);
        start_cond();
        byte_out({ADDR, 1'b1}, a2);
        byte_in(1'b1, d);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask

endmodule

`default_nettype wire

// ===== bench/top_event_flags_and_soft_reset_test.sv
// Purpose: Self-checking bench for the top event flags and soft reset
// Assumes: Host model on the serial port, event pins driven by the bench
// Notes: Inputs change 1 ns after the rising edge of mclk
`timescale 1ns/100ps
`default_nettype none

module top_event_flags_and_soft_reset_test;

    logic mclk, reset_n, scl, host_pull, sda_line, sda_out, sda_oe;
    logic pg, sync, tsd, warn, ovp, meas, gpo_a, gpo_b, otp_reload;
    logic [7:0] ldo_ev, buck_ev;
    logic [3:0] req, reg_en;
    logic [1:0] gpo_req;
    int n_errors, n_compared, otp_cnt;

    assign sda_line = ~(sda_oe | host_pull);

    tef_top_event #(.NUM_REG(4)) dut_u (
        .mclk(mclk), .reset_n(reset_n), .ce(1'b1), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .power_good_output(pg),
        .sync_clk_present(sync), .thermal_shutdown_detect(tsd),
        .thermal_warning_detect(warn), .input_overvoltage_detect(ovp),
        .current_measure_done(meas), .linear_regulator_event_register(ldo_ev),
        .buck_event_register(buck_ev), .regulator_enable_request(req),
        .general_output_request(gpo_req), .regulator_enable(reg_en),
        .general_output_a(gpo_a), .general_output_b(gpo_b), .otp_reload(otp_reload)
    );

    tef_host_model #(.ADDR(tef_pkg::TEF_I2C_ADDR_DEFAULT)) host_u (
        .mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_pull(host_pull)
    );

    always #5 mclk = ~mclk;

    always @(posedge mclk) begin
        if (otp_reload === 1'b1) begin
            otp_cnt <= otp_cnt + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic results();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic rd(input logic [7:0] p, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host_u.read_reg(p, d, ok);
        check({7'h00, ok}, 8'h01);
        check(d, exp);
    endtask

    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic ok;
        host_u.write_reg(p, d, ok);
        check({7'h00, ok}, 8'h01);
    endtask

    // Raises the cause of one latched flag, then takes it away again
    task automatic fire(input int b);
        case (b)
            7: pg = 1'b0;
            4: sync = ~sync;
            3: tsd = 1'b1;
            2: warn = 1'b1;
            1: ovp = 1'b1;
            default: meas = 1'b1;
        endcase
        cyc(2);
        {pg, tsd, warn, ovp, meas} = 5'h10;
        cyc(2);
    endtask

    task automatic toggle_requests();
        req = 4'h0;
        gpo_req = 2'h0;
        cyc(2);
        req = 4'hF;
        gpo_req = 2'h3;
        cyc(3);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset_values();
        rd(tef_pkg::TEF_ADDR_SOFT_RESET, 8'h00);
        rd(tef_pkg::TEF_ADDR_TOP_EVENT, 8'h00);
        rd(8'h30, 8'h00);
    endtask

    // A zero write must leave the flag; a one write clears it
    task automatic t_flags();
        int bits[6] = '{7, 4, 3, 2, 1, 0};
        foreach (bits[k]) begin
            fire(bits[k]);
            rd(8'h19, 8'h01 << bits[k]);
            wr(8'h19, 8'h00);
            rd(8'h19, 8'h01 << bits[k]);
            wr(8'h19, 8'h01 << bits[k]);
            rd(8'h19, 8'h00);
        end
    endtask

    task automatic t_live();
        {tsd, warn, ovp} = 3'h7;
        cyc(3);
        check({4'h0, reg_en}, 8'h00);
        check({6'h00, gpo_b, gpo_a}, 8'h00);
        rd(tef_pkg::TEF_ADDR_LIVE_STATUS, 8'h07);
        {tsd, warn, ovp} = 3'h0;
        cyc(3);
        rd(tef_pkg::TEF_ADDR_LIVE_STATUS, 8'h00);
        rd(8'h19, 8'h0E);
        wr(8'h19, 8'h0E);
    endtask

    // Over-voltage trips but only the thermal flag keeps regulators off
    task automatic t_block();
        toggle_requests();
        check({4'h0, reg_en}, 8'h0F);
        fire(3);
        toggle_requests();
        check({4'h0, reg_en}, 8'h00);
        check({6'h00, gpo_b, gpo_a}, 8'h03);
        wr(8'h19, 8'h08);
        toggle_requests();
        check({4'h0, reg_en}, 8'h0F);
        fire(1);
        check({4'h0, reg_en}, 8'h00);
        toggle_requests();
        check({4'h0, reg_en}, 8'h0F);
        wr(8'h19, 8'hFF);
        rd(8'h19, 8'h00);
    endtask

    task automatic t_summary();
        ldo_ev = 8'h04;
        buck_ev = 8'h10;
        cyc(2);
        rd(8'h19, 8'h60);
        rd(tef_pkg::TEF_ADDR_LDO_EVENT, 8'h04);
        rd(tef_pkg::TEF_ADDR_BUCK_EVENT, 8'h10);
        wr(8'h19, 8'h60);
        rd(8'h19, 8'h60);
        ldo_ev = 8'h00;
        rd(8'h19, 8'h20);
        buck_ev = 8'h00;
        rd(8'h19, 8'h00);
    endtask

    // Cause pulsed in the strobe cycle alone, so only the set can keep the flag
    task automatic t_same_cycle();
        fork
            wr(8'h19, 8'h01);
            begin
                @(posedge dut_u.wr_stb);
                #1;
                meas = 1'b1;
                cyc(1);
                meas = 1'b0;
            end
        join
        rd(8'h19, 8'h01);
        wr(8'h19, 8'h01);
        rd(8'h19, 8'h00);
    endtask

    task automatic t_soft_reset();
        wr(8'h18, 8'hFE);
        rd(8'h18, 8'hFE);
        fire(0);
        fire(7);
        otp_cnt = 0;
        wr(8'h18, 8'h01);
        cyc(4);
        check(otp_cnt[7:0], 8'h01);
        check({6'h00, sda_oe, sda_out}, 8'h00);
        rd(8'h18, 8'h00);
        rd(8'h19, 8'h00);
        wr(8'h19, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        {mclk, reset_n, pg, sync, tsd, warn, ovp, meas} = 8'h20;
        {ldo_ev, buck_ev, req, gpo_req} = {16'h0000, 4'hF, 2'h3};
        {n_errors, n_compared, otp_cnt} = '0;
        cyc(2);
        reset_n = 1'b1;
        cyc(2);
        t_reset_values();
        t_flags();
        t_live();
        t_block();
        t_summary();
        t_same_cycle();
        t_soft_reset();
        results();
    end

    // Roughly 32k cycles of traffic are expected
    initial begin
        repeat (80000) @(posedge mclk);
        n_errors++;
        results();
    end

endmodule

`default_nettype wire

// ===== include/tef_pkg.sv
// Purpose: Shared constants for the top event flag and soft reset block
// Assumes: Registers reached over the I2C-compatible serial port only
// Notes: Offsets are byte pointers of the serial register space
//
// Notes on behaviour
// - Soft reset restores defaults, reloads OTP, resets serial
// - Soft-reset bit clears itself after triggering
// - Soft-reset bits 7..1 reserved, reset to zero
// - Bit 7 latches on power-good falling
// - Bit 6 mirrors any pending linear-regulator cause
// - Bit 5 mirrors any pending buck cause
// - Bit 4 latches on sync clock change
// - Thermal shutdown latches bit 3, kills outputs
// - Latched shutdown flag refuses every regulator enable
// - Live thermal shutdown status readable separately
// - Bit 2 latches warning; live warning separate
// - Over-voltage latches bit 1, kills outputs
// - Live over-voltage status readable separately
// - Buck cause detail readable in its own register
// - Bit 0 latches when current result ready
`default_nettype none

package tef_pkg;

    // Register pointers
    localparam logic [7:0] TEF_ADDR_SOFT_RESET = 8'h18;
    localparam logic [7:0] TEF_ADDR_TOP_EVENT = 8'h19;
    localparam logic [7:0] TEF_ADDR_LIVE_STATUS = 8'h1C;
    localparam logic [7:0] TEF_ADDR_LDO_EVENT = 8'h1D;
    localparam logic [7:0] TEF_ADDR_BUCK_EVENT = 8'h1E;

    // Top event register fields
    localparam int TEF_BIT_PG = 7;
    localparam int TEF_BIT_LDO = 6;
    localparam int TEF_BIT_BUCK = 5;
    localparam int TEF_BIT_SYNC = 4;
    localparam int TEF_BIT_TSD = 3;
    localparam int TEF_BIT_TWARN = 2;
    localparam int TEF_BIT_OVP = 1;
    localparam int TEF_BIT_MEAS = 0;
    localparam logic [7:0] TEF_LATCHED_MASK = 8'h9F;

    // Live status fields
    localparam int TEF_LIVE_TSD = 2;
    localparam int TEF_LIVE_TWARN = 1;
    localparam int TEF_LIVE_OVP = 0;

    // Soft reset register field
    localparam int TEF_BIT_SOFT_RESET = 0;

    // Reset values
    localparam logic [6:0] TEF_SOFT_RSVD_RST = 7'h00;
    localparam logic TEF_FLAG_RST = 1'b0;
    localparam logic [7:0] TEF_PTR_RST = 8'h00;

    // Serial framing
    localparam logic [3:0] TEF_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] TEF_LAST_READ_BIT = 4'h7;

    // Arbitrary neutral bus address
    localparam logic [6:0] TEF_I2C_ADDR_DEFAULT = 7'h2A;

endpackage

`default_nettype wire

// ===== src/tef_flag_cell.sv
// Purpose: One sticky event flag with write-one-to-clear
// Assumes: Set, clear and soft reset are single-cycle qualified levels
// Notes: Soft reset restores the default over everything else
`timescale 1ns/100ps
`default_nettype none

module tef_flag_cell (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic set_evt,
    input wire logic clear_w1c,
    input wire logic soft_rst,
    output logic flag
);

    logic next_flag;

    // A clear in the same cycle as an event loses, so no event is dropped
    assign next_flag = soft_rst ? tef_pkg::TEF_FLAG_RST
                     : (set_evt | (flag & ~clear_w1c));

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            flag <= tef_pkg::TEF_FLAG_RST;
        end else if (ce) begin
            flag <= next_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    set_wins_a: assert property (@(posedge mclk) disable iff (!reset_n)
        ce && set_evt && !soft_rst |=> flag)
        else $error("event lost against clear");

    clear_one_a: assert property (@(posedge mclk) disable iff (!reset_n)
        ce && flag && clear_w1c && !set_evt |=> !flag)
        else $error("write one did not clear flag");

endmodule

`default_nettype wire

// ===== src/tef_top_event.sv
// Purpose: Top event flags, live status and soft reset behind a serial slave
// Assumes: Pin inputs are synchronous to mclk; SCL far slower than mclk
// Notes: SDA is open drain, sda_oe high pulls the line low
`timescale 1ns/100ps
`default_nettype none

module tef_top_event #(
    parameter int NUM_REG = 4,
    parameter logic [6:0] DEV_ADDR = tef_pkg::TEF_I2C_ADDR_DEFAULT
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic power_good_output,
    input wire logic sync_clk_present,
    input wire logic thermal_shutdown_detect,
    input wire logic thermal_warning_detect,
    input wire logic input_overvoltage_detect,
    input wire logic current_measure_done,
    input wire logic [7:0] linear_regulator_event_register,
    input wire logic [7:0] buck_event_register,
    input wire logic [NUM_REG-1:0] regulator_enable_request,
    input wire logic [1:0] general_output_request,
    output logic [NUM_REG-1:0] regulator_enable,
    output logic general_output_a,
    output logic general_output_b,
    output logic otp_reload
);

    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_REG,
        S_WDATA,
        S_ACK,
        S_RDATA,
        S_RACK
    } tef_i2c_state_t;

    tef_i2c_state_t state;
    tef_i2c_state_t after_ack;
    logic scl_q, sda_q, scl_p, sda_p;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_pending;
    logic wr_stb;
    logic soft_reset_trigger;
    logic [6:0] soft_rsvd;
    logic pg_p, sync_p, tsd_p, twarn_p, ovp_p;
    logic [NUM_REG-1:0] reg_tripped;
    logic [1:0] gpo_tripped;

    ////////////////////////////////////////////////////////////////////////
    // Decode

    logic start_det, stop_det, scl_rise, scl_fall;
    logic soft_rst;
    logic wr_soft, wr_top;
    logic pg_fall, sync_chg, tsd_rise, twarn_rise, ovp_rise, trip;
    logic tsd_block;
    logic [7:0] flag_set, flag_w1c, flag_q;
    logic [7:0] top_read, live_status, rd_data;
    logic [NUM_REG-1:0] next_reg_tripped, next_reg_en;
    logic [1:0] next_gpo_tripped, next_gpo;

    assign start_det = scl_q & scl_p & sda_p & ~sda_q;
    assign stop_det = scl_q & scl_p & ~sda_p & sda_q;
    assign scl_rise = scl_q & ~scl_p;
    assign scl_fall = ~scl_q & scl_p;

    // The trigger bit is itself the one-cycle reset pulse
    assign soft_rst = soft_reset_trigger;
    assign wr_soft = wr_stb && (wr_addr == tef_pkg::TEF_ADDR_SOFT_RESET);
    assign wr_top = wr_stb && (wr_addr == tef_pkg::TEF_ADDR_TOP_EVENT);

    assign pg_fall = pg_p & ~power_good_output;
    assign sync_chg = sync_p ^ sync_clk_present;
    assign tsd_rise = thermal_shutdown_detect & ~tsd_p;
    assign twarn_rise = thermal_warning_detect & ~twarn_p;
    assign ovp_rise = input_overvoltage_detect & ~ovp_p;
    assign trip = tsd_rise | ovp_rise;

    assign flag_set[tef_pkg::TEF_BIT_PG] = pg_fall;
    assign flag_set[tef_pkg::TEF_BIT_LDO] = 1'b0;
    assign flag_set[tef_pkg::TEF_BIT_BUCK] = 1'b0;
    assign flag_set[tef_pkg::TEF_BIT_SYNC] = sync_chg;
    assign flag_set[tef_pkg::TEF_BIT_TSD] = tsd_rise;
    assign flag_set[tef_pkg::TEF_BIT_TWARN] = twarn_rise;
    assign flag_set[tef_pkg::TEF_BIT_OVP] = ovp_rise;
    assign flag_set[tef_pkg::TEF_BIT_MEAS] = current_measure_done;
    assign flag_w1c = wr_top ? wr_data : 8'h00;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : gen_flag
            if (tef_pkg::TEF_LATCHED_MASK[g]) begin : gen_cell
                tef_flag_cell u_cell (
                    .mclk(mclk),
                    .reset_n(reset_n),
                    .ce(ce),
                    .set_evt(flag_set[g]),
                    .clear_w1c(flag_w1c[g]),
                    .soft_rst(soft_rst),
                    .flag(flag_q[g])
                );
            end else begin : gen_none
                assign flag_q[g] = 1'b0;
            end
        end
    endgenerate

    // Summary bits follow their source registers, so they clear on their own
    always_comb begin
        top_read = flag_q & tef_pkg::TEF_LATCHED_MASK;
        top_read[tef_pkg::TEF_BIT_LDO] = |linear_regulator_event_register;
        top_read[tef_pkg::TEF_BIT_BUCK] = |buck_event_register;
        live_status = 8'h00;
        live_status[tef_pkg::TEF_LIVE_TSD] = thermal_shutdown_detect;
        live_status[tef_pkg::TEF_LIVE_TWARN] = thermal_warning_detect;
        live_status[tef_pkg::TEF_LIVE_OVP] = input_overvoltage_detect;
    end

    assign rd_data =
        (ptr == tef_pkg::TEF_ADDR_SOFT_RESET) ? {soft_rsvd, soft_reset_trigger} :
        (ptr == tef_pkg::TEF_ADDR_TOP_EVENT) ? top_read :
        (ptr == tef_pkg::TEF_ADDR_LIVE_STATUS) ? live_status :
        (ptr == tef_pkg::TEF_ADDR_LDO_EVENT) ? linear_regulator_event_register :
        (ptr == tef_pkg::TEF_ADDR_BUCK_EVENT) ? buck_event_register :
        8'h00;

    // A trip holds a channel off until its request is dropped and raised again
    assign tsd_block = flag_q[tef_pkg::TEF_BIT_TSD] | tsd_rise;
    assign next_reg_tripped = trip ? {NUM_REG{1'b1}}
                            : (reg_tripped & regulator_enable_request);
    assign next_reg_en = regulator_enable_request & ~next_reg_tripped
                       & {NUM_REG{~tsd_block}};
    assign next_gpo_tripped = trip ? 2'h3 : (gpo_tripped & general_output_request);
    assign next_gpo = general_output_request & ~next_gpo_tripped;

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling, edge history and outputs

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
            pg_p <= 1'b0;
            sync_p <= 1'b0;
            tsd_p <= 1'b0;
            twarn_p <= 1'b0;
            ovp_p <= 1'b0;
            reg_tripped <= '0;
            gpo_tripped <= 2'h0;
            regulator_enable <= '0;
            general_output_a <= 1'b0;
            general_output_b <= 1'b0;
            otp_reload <= 1'b0;
            sda_out <= 1'b0;
        end else if (ce) begin
            scl_q <= scl_in;
            sda_q <= sda_in;
            scl_p <= scl_q;
            sda_p <= sda_q;
            pg_p <= power_good_output;
            sync_p <= sync_clk_present;
            tsd_p <= thermal_shutdown_detect;
            twarn_p <= thermal_warning_detect;
            ovp_p <= input_overvoltage_detect;
            reg_tripped <= next_reg_tripped;
            gpo_tripped <= next_gpo_tripped;
            regulator_enable <= next_reg_en;
            general_output_a <= next_gpo[0];
            general_output_b <= next_gpo[1];
            otp_reload <= soft_rst;
            sda_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Soft reset register

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            soft_reset_trigger <= 1'b0;
            soft_rsvd <= tef_pkg::TEF_SOFT_RSVD_RST;
        end else if (ce) begin
            if (soft_rst) begin
                soft_reset_trigger <= 1'b0;
                soft_rsvd <= tef_pkg::TEF_SOFT_RSVD_RST;
            end else if (wr_soft) begin
                soft_reset_trigger <= wr_data[tef_pkg::TEF_BIT_SOFT_RESET];
                soft_rsvd <= wr_data[7:1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial slave: pointer byte, then writes or reads with auto-increment.
    // Writes commit at the end of the ACK so a soft reset still gets acked.

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= S_IDLE;
            after_ack <= S_IDLE;
            cnt <= 4'h0;
            shreg <= 8'h00;
            ptr <= tef_pkg::TEF_PTR_RST;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
            wr_pending <= 1'b0;
            wr_stb <= 1'b0;
            sda_oe <= 1'b0;
        end else if (ce) begin
            wr_stb <= 1'b0;
            if (soft_rst) begin
                state <= S_IDLE;
                ptr <= tef_pkg::TEF_PTR_RST;
                wr_pending <= 1'b0;
                sda_oe <= 1'b0;
            end else if (stop_det) begin
                state <= S_IDLE;
                wr_pending <= 1'b0;
                sda_oe <= 1'b0;
            end else if (start_det) begin
                state <= S_ADDR;
                cnt <= 4'h0;
                wr_pending <= 1'b0;
                sda_oe <= 1'b0;
            end else begin
                unique case (state)
                    S_IDLE: begin
                        cnt <= 4'h0;
                    end
                    S_ADDR, S_REG, S_WDATA: begin
                        if (scl_rise) begin
                            shreg <= {shreg[6:0], sda_q};
                            cnt <= cnt + 4'h1;
                        end else if (scl_fall && cnt == tef_pkg::TEF_BITS_PER_BYTE) begin
                            cnt <= 4'h0;
                            if (state == S_ADDR && shreg[7:1] != DEV_ADDR) begin
                                state <= S_IDLE;
                            end else begin
                                sda_oe <= 1'b1;
                                state <= S_ACK;
                                wr_pending <= (state == S_WDATA);
                                if (state == S_ADDR) begin
                                    after_ack <= shreg[0] ? S_RDATA : S_REG;
                                end else begin
                                    after_ack <= S_WDATA;
                                end
                                if (state == S_REG) begin
                                    ptr <= shreg;
                                end
                            end
                        end
                    end
                    S_ACK: begin
                        if (scl_fall) begin
                            state <= after_ack;
                            wr_pending <= 1'b0;
                            if (wr_pending) begin
                                wr_stb <= 1'b1;
                                wr_addr <= ptr;
                                wr_data <= shreg;
                                ptr <= ptr + 8'h01;
                            end
                            if (after_ack == S_RDATA) begin
                                shreg <= {rd_data[6:0], 1'b0};
                                sda_oe <= ~rd_data[7];
                                ptr <= ptr + 8'h01;
                            end else begin
                                sda_oe <= 1'b0;
                            end
                        end
                    end
                    S_RDATA: begin
                        if (scl_fall) begin
                            if (cnt == tef_pkg::TEF_LAST_READ_BIT) begin
                                cnt <= 4'h0;
                                sda_oe <= 1'b0;
                                state <= S_RACK;
                            end else begin
                                cnt <= cnt + 4'h1;
                                sda_oe <= ~shreg[7];
                                shreg <= {shreg[6:0], 1'b0};
                            end
                        end
                    end
                    S_RACK: begin
                        if (scl_rise && sda_q) begin
                            state <= S_IDLE;
                        end else if (scl_fall) begin
                            shreg <= {rd_data[6:0], 1'b0};
                            sda_oe <= ~rd_data[7];
                            ptr <= ptr + 8'h01;
                            state <= S_RDATA;
                        end
                    end
                    default: begin
                        state <= S_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    soft_reload_a: assert property (
        ce && soft_reset_trigger |=> otp_reload && state == S_IDLE
            && (flag_q & tef_pkg::TEF_LATCHED_MASK) == 8'h00)
        else $error("soft reset did not restore block");

    soft_self_clear_a: assert property (
        ce && soft_reset_trigger |=> !soft_reset_trigger)
        else $error("soft reset bit did not clear itself");

    rsvd_zero_a: assert property (
        otp_reload |-> soft_rsvd == 7'h00)
        else $error("reserved bits survived soft reset");

    pg_latch_a: assert property (
        ce && pg_fall && !soft_rst |=> flag_q[tef_pkg::TEF_BIT_PG])
        else $error("power-good fall not latched");

    tsd_kill_a: assert property (
        ce && tsd_rise |=> regulator_enable == '0 && !general_output_a
            && !general_output_b && ($past(soft_rst) || flag_q[tef_pkg::TEF_BIT_TSD]))
        else $error("thermal shutdown left outputs on");

    tsd_refuse_a: assert property (
        flag_q[tef_pkg::TEF_BIT_TSD] |-> regulator_enable == '0)
        else $error("regulator enabled under shutdown flag");

    ovp_kill_a: assert property (
        ce && ovp_rise |=> regulator_enable == '0 && !general_output_a
            && !general_output_b)
        else $error("over-voltage left outputs on");

endmodule

`default_nettype wire
